// *** dv/tb_top.sv ***
// Self-checking bench of the side-information parser
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
// ============================================================================
// Bench
module tb_top
  import tsp_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic        br_req, br_valid, br_bit, busy;
  tsp_svreq_t  sv_req;
  tsp_svans_t  sv_ans;
  tsp_result_t result;
  int          miscompares = 0;
  int          n_compared = 0;
  // Register rows: address, write value, read-back
  typedef struct packed {logic [3:0] a; logic [31:0] w; logic [31:0] r;} tsp_row_t;
  tsp_row_t    rows [4] = '{'{REG_CFG, 32'h0A7F, 32'h0A7F}, '{REG_GEOM, 32'h43050, 32'h43050},
                            '{REG_STAT, 32'hFFFF_FFFF, 32'h0}, '{4'h2, 32'h5, 32'h0}};
  tsp_parser DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .br_req(br_req),
    .br_valid(br_valid), .br_bit(br_bit), .sv_req(sv_req), .sv_ans(sv_ans),
    .result(result), .busy(busy));
  tsp_far u_far (.clk(clk), .br_req(br_req), .br_valid(br_valid), .br_bit(br_bit),
    .sv_req(sv_req), .sv_ans(sv_ans));
  always #4 clk = ~clk;
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One-cycle strobes; read data sampled in the cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Load the far side, start a frame, wait bounded for the end
  task automatic frame(input logic [31:0] cfg, geom, input logic [15:0] bits, input int nb,
                       input logic [79:0] vals, input int nv, input logic sl);
    int i;
    for (i = nb - 1; i >= 0; i--)
      u_far.bq.push_back(bits[i]);
    for (i = nv - 1; i >= 0; i--)
      u_far.vq.push_back(vals[8*i +: 8]);
    u_far.slow <= sl;
    wr(REG_CFG, cfg);
    wr(REG_GEOM, geom);
    wr(REG_CTRL, 32'h1);
    for (i = 0; i < 2000 && (busy !== 1'b0 || i < 2); i++)
      @(posedge clk);
    if (busy !== 1'b0)
    begin
      miscompares++;
      final_report();
    end
    `CHK("bits left", 0, u_far.bq.size())
    `CHK("values left", 0, u_far.vq.size())
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(REG_CFG);
    `CHK("cfg reset", CFG_RST, d)
    rd(REG_GEOM);
    `CHK("geom reset", GEOM_RST, d)
    for (int i = 0; i < 4; i++)
    begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK("register", rows[i].r, d)
    end
    // Independent frame, one filter, odd rate: no harmonic bits, level 2, zero vector
    frame(32'h3, 32'h11050, 16'b1011011, 7, 32'h0103, 2, 1'b0);
    `CHK("active", 2'b01, result.tns_active)
    `CHK("order", 4'h1, result.tns_order[0])
    `CHK("coef", 4'h3, result.tns_coef[0][0])
    `CHK("hm off", 1'b0, result.hm_on)
    `CHK("level", 2'h2, result.wl[0][0])
    `CHK("flat", 1'b1, result.flat[0])
    `CHK("zero", 1'b1, result.zero[0])
    `CHK("sf", 10'h0, result.sf[0][0])
    rd(REG_STAT);
    `CHK("done", 1'b1, d[1])
    // Two filters, first order 1 coef 0; harmonic interval; levels reused; slow far side
    frame(32'h2, 32'h110F4, 16'b11110100101101, 14, 32'h0100_0107, 4, 1'b1);
    `CHK("active2", 2'b10, result.tns_active)
    `CHK("order2", 4'h1, result.tns_order[1])
    `CHK("hm on", 1'b1, result.hm_on)
    `CHK("interval", 8'hA5, result.hm_interval)
    `CHK("reuse", 2'h2, result.wl[0][0])
    `CHK("flat2", 1'b0, result.flat[0])
    // Half split: coded scale factors, escape, then time prediction in slot one
    frame(32'h100, 32'h21050, 16'b0100110, 7, 80'h0501_001A_0000_0101_0D0E, 10, 1'b0);
    `CHK("sf0", 10'h016, result.sf[0][0])
    `CHK("sf1", 10'h026, result.sf[0][1])
    `CHK("sf2", 10'h016, result.sf[1][0])
    `CHK("sf3", 10'h027, result.sf[1][1])
    `CHK("flat3", 2'b10, result.flat)
    final_report();
  end
endmodule

// *** dv/tsp_far.sv ***
// Far-side model: bit reader and shared symbol service
`timescale 1ns/10ps
// ============================================================================
// Reader and service
module tsp_far
  import tsp_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Bit reader
  input  wire logic       br_req,
  output logic            br_valid,
  output logic            br_bit,
  // Symbol service
  input  wire tsp_svreq_t sv_req,
  output tsp_svans_t      sv_ans
);
  logic       bq[$];
  logic [7:0] vq[$];
  logic       slow = 1'b0;
  logic       ph = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial
  begin
    br_valid = 1'b0;
    br_bit = 1'b0;
    sv_ans = '0;
  end
  // Bits in stream order; a released line toggles so stale data never looks valid
  always @(posedge clk)
  begin
    ph <= ~ph;
    if (br_req && br_valid)
      void'(bq.pop_front());
    if (bq.size() != 0 && !(slow && ph))
    begin
      br_valid <= 1'b1;
      br_bit <= bq[0];
    end
    else
    begin
      br_valid <= 1'b0;
      br_bit <= ~br_bit;
    end
  end
  // One ack per request; init and flush only acknowledged, no coder kept
  always @(posedge clk)
  begin
    sv_ans.ack <= 1'b0;
    sv_ans.value <= ~sv_ans.value;
    sv_ans.offset <= 8'sh00;
    if (sv_req.req && !sv_ans.ack)
      if (cnt == (slow ? 2'h3 : 2'h0))
      begin
        sv_ans.ack <= 1'b1;
        sv_ans.value <= (vq.size() != 0 && !(sv_req.cmd inside {SV_AD_INIT, SV_AD_FLUSH}))
                        ? vq.pop_front() : 8'h00;
        cnt <= 2'h0;
      end
      else
        cnt <= cnt + 2'h1;
  end
endmodule

// *** dv/tsp_monitor.sv ***
// Port checker of the side-information parser, bound to its top
`timescale 1ns/10ps
// ============================================================================
// Checker
module tsp_monitor
  import tsp_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Far side
  input wire logic        br_req,
  input wire logic        br_valid,
  input wire logic        br_bit,
  input wire tsp_svreq_t  sv_req,
  input wire tsp_svans_t  sv_ans,
  // Results
  input wire tsp_result_t result,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Frame start and two idle cycles
  sequence go_idle;
    reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO] && !busy;
  endsequence
  sequence quiet_two;
    !busy [*2];
  endsequence
  rd_window_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside its cycle");
  rd_unmapped_a: assert property (reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  start_flag_a: assert property (go_idle |=> busy && br_req)
    else $error("frame start without flag bit request");
  start_cause_a: assert property ($rose(busy) |-> $past(reg_wr) && $past(reg_addr) == REG_CTRL)
    else $error("frame started without go");
  result_clear_a: assert property (go_idle |=> result == '0)
    else $error("result not cleared at frame start");
  bit_hold_a: assert property (br_req && !br_valid |=> br_req)
    else $error("bit request dropped before taken");
  sv_hold_a: assert property (sv_req.req && !sv_ans.ack |=> sv_req.req && $stable(sv_req))
    else $error("service request changed before ack");
  idle_quiet_a: assert property (quiet_two |-> !br_req && !sv_req.req)
    else $error("requests while idle");
endmodule
bind tsp_parser tsp_monitor u_mon (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .br_req(br_req), .br_valid(br_valid), .br_bit(br_bit), .sv_req(sv_req),
  .sv_ans(sv_ans), .result(result), .busy(busy));

// *** hdl/tsp_parser.sv ***
// Side-information parser: shaping filter, harmonic model, band-extension data
`timescale 1ns/10ps
// ============================================================================
// How it works
// - Read one shaping-filter on/off bit
// - Extra bit picks one or two filters
// - Each filter: variable-length order, then coefficients
// - One filter received: second filter inactive
// - Two filters, first order1 coef0: first disabled
// - Harmonic model off: rate, predictive, coder type
// - Harmonic flag read; interval only when set
// - No pitch or low gain: 8-bit interval
// - Envelope coding and voiced: 2-bit gain
// - Whitening levels: reuse, tile0, copy or individual
// - Level prefix code: 0=1, 11=2, 10=0
// - Flatness bit follows whitening levels
// - Half split: both sub-frames buffered by index
// - Zero flag clears scale factors and state
// - Raw value built MSB first from coded bits
// - Inner symbol: minus one, bound, table offset
// - Edge symbols escape with 4, 6, 7 bits
// - Band 0 without prediction: symbol*4 plus LSBs
// - Predictor state: selector and previous vector
// - Coder initialised before, flushed after vector
// ============================================================================
module tsp_parser
  import tsp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Bit reader
  output logic             br_req,
  input  wire logic        br_valid,
  input  wire logic        br_bit,
  // Symbol service (arithmetic core and code tables)
  output tsp_svreq_t       sv_req,
  input  wire tsp_svans_t  sv_ans,
  // Decoded results
  output tsp_result_t      result,
  output logic             busy
);

  tsp_state_t q;
  tsp_state_t n;

  // ==========================================================================
  // Configuration fields and working signals
  logic                        indep;
  logic                        env;
  logic                        voiced;
  logic                        hm_off;
  logic                        sf_t_eff;
  logic                        fin;
  logic                        adv;
  logic                        go;
  tsp_split_t                  split;
  logic [3:0]                  tiles;
  logic [3:0]                  bands;
  logic [9:0]                  rate;
  logic [3:0]                  km1;
  logic [3:0]                  km2;
  logic [7:0]                  extra;
  logic signed [VAL_W-1:0]     gm1;
  logic signed [VAL_W-1:0]     gm2;
  logic signed [VAL_W-1:0]     pv;
  logic signed [VAL_W-1:0]     pvm1;
  logic signed [VAL_W-1:0]     pred;
  logic signed [VAL_W-1:0]     xval;
  logic [3:0]                  sf_cls;
  logic [7:0]                  sf_tab;

  assign indep  = q.cfg[CFG_INDEP];
  assign env    = q.cfg[CFG_ENV];
  assign voiced = q.cfg[CFG_CT+:2] == CT_VOICED;
  assign split  = tsp_split_t'(q.cfg[CFG_SPLIT+:2]);
  assign rate   = q.geom[GEOM_RATE+:10];
  assign tiles  = {1'b0, q.geom[GEOM_TILES+:3]};
  assign bands  = q.geom[GEOM_BANDS+:4];
  assign go     = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_GO] && !q.busy;

  // Harmonic model is skipped silently, no flag bit is spent
  assign hm_off = !(rate == RATE_0 || rate == RATE_1 || rate == RATE_2 ||
                    rate == RATE_3 || rate == RATE_4 || rate == RATE_5) ||
                  q.cfg[CFG_PREV_PRED] ||
                  (env && !voiced && q.cfg[CFG_CT+:2] != CT_GENERIC);

  // ==========================================================================
  // Scale-factor prediction and context
  assign sf_t_eff = q.sf_t && !indep;
  assign km1  = (q.k == 4'h0) ? 4'h0 : q.k - 4'h1;
  assign km2  = (q.k < 4'h2) ? 4'h0 : q.k - 4'h2;
  assign gm1  = VAL_W'($signed(q.res.sf[q.sub][km1]));
  assign gm2  = VAL_W'($signed(q.res.sf[q.sub][km2]));
  assign pv   = VAL_W'($signed(q.prev_sf[q.k]));
  assign pvm1 = VAL_W'($signed(q.prev_sf[km1]));

  // Clamped neighbour difference, shifted to a table index
  function automatic logic [3:0] qctx(input logic signed [VAL_W-1:0] d);
    logic signed [VAL_W-1:0] c;
    c = (d > CTX_LIM) ? CTX_LIM : (d < -CTX_LIM) ? -CTX_LIM : d;
    return 4'(c + CTX_LIM);
  endfunction

  // Predictor and table choice per band
  always_comb
  begin
    pred   = gm1;
    sf_tab = 8'h00;
    if (!sf_t_eff)
    begin
      sf_cls = (q.k == 4'h0) ? TAB_SE00 : (q.k == 4'h1) ? TAB_SE01 : TAB_SE02;
      if (q.k >= 4'h2)
        sf_tab = {4'h0, qctx(gm1 - gm2)};
    end
    else if (q.k == 4'h0)
    begin
      sf_cls = TAB_SE10;
      pred   = pv;
    end
    else
    begin
      sf_cls = TAB_SE11;
      pred   = pv + gm1 - pvm1;
      sf_tab = {qctx(gm1 - pvm1), qctx(pv - pvm1)};
    end
  end

  // ==========================================================================
  // Helpers that launch a field read or a service request
  function automatic tsp_state_t rd(input tsp_state_t s, input tsp_state_e_t r,
                                    input logic [3:0] cnt, input logic ad);
    tsp_state_t o;
    o        = s;
    o.st     = ad ? ST_AD_RD : ST_RD;
    o.ret    = r;
    o.need   = cnt;
    o.acc    = 8'h00;
    o.sv.cmd = SV_AD_BIT;
    return o;
  endfunction

  function automatic tsp_state_t svc(input tsp_state_t s, input tsp_state_e_t r,
                                     input tsp_cmd_t c, input logic [3:0] a,
                                     input logic [7:0] b);
    tsp_state_t o;
    o          = s;
    o.st       = ST_SV;
    o.ret      = r;
    o.sv.cmd   = c;
    o.sv.tab_a = a;
    o.sv.tab_b = b;
    return o;
  endfunction

  // ==========================================================================
  // Next-state logic: register port and parser sequence
  always_comb
  begin
    n       = q;
    fin     = 1'b0;
    adv     = 1'b0;
    xval    = '0;
    extra   = 8'h00;
    n.rdata = 32'h0000_0000;
    // Config writes act live; software keeps them still while busy
    if (reg_wr && reg_addr == REG_CFG)
      n.cfg = reg_wdata;
    if (reg_wr && reg_addr == REG_GEOM)
      n.geom = reg_wdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CFG:  n.rdata = q.cfg;
        REG_GEOM: n.rdata = q.geom;
        REG_STAT: n.rdata = {12'h000, q.res.zero, q.res.flat, q.res.tns_active,
                             q.res.hm_on, q.sub, 3'h0, q.st, 2'h0, q.done, q.busy};
        default:  n.rdata = 32'h0000_0000;
      endcase
    end
    unique case (q.st)
      ST_IDLE:
        if (go)
        begin
          n.res  = '0;
          n.busy = 1'b1;
          n.done = 1'b0;
          n.sub  = 1'b0;
          n      = rd(n, ST_TNS_ON, ONE_BIT, 1'b0);
        end
      // Bits come in stream order from the reader
      ST_RD:
        if (br_valid)
        begin
          n.acc  = {q.acc[6:0], br_bit};
          n.need = q.need - 4'h1;
          if (q.need == 4'h1)
            n.st = q.ret;
        end
      ST_AD_RD:
        if (sv_ans.ack)
        begin
          n.acc  = {q.acc[6:0], sv_ans.value[0]};
          n.need = q.need - 4'h1;
          if (q.need == 4'h1)
            n.st = q.ret;
        end
      ST_SV:
        if (sv_ans.ack)
        begin
          n.acc = sv_ans.value;
          n.off = sv_ans.offset;
          n.st  = q.ret;
        end
      ST_TNS_ON:
        if (!q.acc[0])
          n.st = ST_HM_CHK;
        else if (q.cfg[CFG_TWO_OK])
          n = rd(n, ST_TNS_CNT, ONE_BIT, 1'b0);
        else
        begin
          n.nfilt = 1'b0;
          n.filt  = 1'b0;
          n = svc(n, ST_TNS_ORD, SV_VLC_ORDER, {1'b0, q.cfg[CFG_BW], split}, 8'h00);
        end
      ST_TNS_CNT:
      begin
        n.nfilt = q.acc[0];
        n.filt  = 1'b0;
        n = svc(n, ST_TNS_ORD, SV_VLC_ORDER, {1'b0, q.cfg[CFG_BW], split}, 8'h00);
      end
      ST_TNS_ORD:
      begin
        n.ord = (q.acc > 8'(MAX_ORDER)) ? 4'(MAX_ORDER) : q.acc[3:0];
        n.res.tns_order[q.filt] = n.ord;
        n.k = 4'h0;
        if (n.ord == 4'h0)
          n.st = ST_TNS_END;
        else
          n = svc(n, ST_TNS_COEF, SV_VLC_COEF, {1'b0, q.cfg[CFG_BW], split}, 8'h00);
      end
      ST_TNS_COEF:
      begin
        n.res.tns_coef[q.filt][q.k[2:0]] = q.acc[COEF_W-1:0];
        if (q.k + 4'h1 < q.ord)
        begin
          n.k = q.k + 4'h1;
          n = svc(n, ST_TNS_COEF, SV_VLC_COEF, {1'b0, q.cfg[CFG_BW], split},
                  {4'h0, n.k});
        end
        else
          n.st = ST_TNS_END;
      end
      ST_TNS_END:
        if (q.filt != q.nfilt)
        begin
          n.filt = 1'b1;
          n = svc(n, ST_TNS_ORD, SV_VLC_ORDER, {1'b0, q.cfg[CFG_BW], split}, 8'h00);
        end
        else
        begin
          n.st = ST_HM_CHK;
          if (!q.nfilt)
            n.res.tns_active = 2'b01;
          else if (q.res.tns_order[0] == 4'h1 && q.res.tns_coef[0][0] == '0)
            n.res.tns_active = 2'b10;
          else
            n.res.tns_active = 2'b11;
        end
      ST_HM_CHK:
        if (hm_off)
          n.st = ST_WL_CHK;
        else
          n = rd(n, ST_HM_FLAG, ONE_BIT, 1'b0);
      ST_HM_FLAG:
      begin
        n.res.hm_on = q.acc[0];
        if (!q.acc[0])
          n.st = ST_WL_CHK;
        else if (!q.cfg[CFG_LTP] || q.cfg[CFG_LTP_LOW])
          n = rd(n, ST_HM_INT, HM_IDX_BITS, 1'b0);
        else
          n = rd(n, ST_HM_INT, HM_MUL_BITS, 1'b0);
      end
      ST_HM_INT:
      begin
        n.res.hm_interval = q.acc;
        if (env && voiced)
          n = rd(n, ST_HM_GAIN, HM_GAIN_BITS, 1'b0);
        else
          n.st = ST_WL_CHK;
      end
      ST_HM_GAIN:
      begin
        n.res.hm_gain = q.acc[1:0];
        n.st = ST_WL_CHK;
      end
      // Independent frames skip the reuse bit
      ST_WL_CHK:
      begin
        n.k = 4'h0;
        n = rd(n, indep ? ST_WL_LVL : ST_WL_REUSE, ONE_BIT, 1'b0);
      end
      ST_WL_REUSE:
        if (q.acc[0])
        begin
          n.res.wl[q.sub] = q.prev_wl;
          n.st = ST_WL_SAVE;
        end
        else
          n = rd(n, ST_WL_LVL, ONE_BIT, 1'b0);
      ST_WL_LVL:
        if (!q.acc[0])
        begin
          n.res.wl[q.sub][q.k[1:0]] = 2'h1;
          n.st = ST_WL_NEXT;
        end
        else
          n = rd(n, ST_WL_LVL2, ONE_BIT, 1'b0);
      ST_WL_LVL2:
      begin
        n.res.wl[q.sub][q.k[1:0]] = q.acc[0] ? 2'h2 : 2'h0;
        n.st = ST_WL_NEXT;
      end
      ST_WL_NEXT:
        if (q.k == 4'h0)
          n = rd(n, ST_WL_MODE, ONE_BIT, 1'b0);
        else if (q.k + 4'h1 < tiles)
        begin
          n.k = q.k + 4'h1;
          n = rd(n, ST_WL_LVL, ONE_BIT, 1'b0);
        end
        else
          n.st = ST_WL_SAVE;
      ST_WL_MODE:
        if (q.acc[0] && tiles > 4'h1)
        begin
          n.k = 4'h1;
          n = rd(n, ST_WL_LVL, ONE_BIT, 1'b0);
        end
        else
        begin
          for (int i = 1; i < MAX_TILES; i++)
            if (!q.acc[0])
              n.res.wl[q.sub][i] = q.res.wl[q.sub][0];
          n.st = ST_WL_SAVE;
        end
      ST_WL_SAVE:
      begin
        n.prev_wl = q.res.wl[q.sub];
        n = rd(n, ST_FLAT, ONE_BIT, 1'b0);
      end
      ST_FLAT:
      begin
        n.res.flat[q.sub] = q.acc[0];
        n = rd(n, ST_ZERO, ONE_BIT, 1'b0);
      end
      ST_ZERO:
      begin
        n.res.zero[q.sub] = q.acc[0];
        n.k = 4'h0;
        if (q.acc[0])
        begin
          n.res.sf[q.sub] = '0;
          n.prev_sf = '0;
          n.sf_t = 1'b0;
          n.st = ST_SUB_END;
        end
        else
          n = svc(n, ST_SF_REQ, SV_AD_INIT, 4'h0, 8'h00);
      end
      ST_SF_REQ:
        n = svc(n, ST_SF_SYM, SV_AD_SYM, sf_cls, sf_tab);
      ST_SF_SYM:
        if (!sf_t_eff && q.k == 4'h0)
        begin
          n.res.sf[q.sub][0] = SF_W'({q.acc, 2'b00});
          n = rd(n, ST_SF_LSB, LSB_BITS, 1'b1);
        end
        else if (q.acc[4:0] != 5'h00 && q.acc[4:0] != SYM_LAST)
        begin
          fin  = 1'b1;
          xval = VAL_W'(q.acc) - 12'sh001 + LOWER_SEP;
        end
        else
        begin
          n.hi_side = q.acc[4:0] == SYM_LAST;
          n = rd(n, ST_SF_E4, E4_BITS, 1'b1);
        end
      ST_SF_LSB:
      begin
        n.res.sf[q.sub][0] = q.res.sf[q.sub][0] + SF_W'(q.acc[1:0]);
        adv = 1'b1;
      end
      ST_SF_E4:
        if (q.acc == E4_ESC)
          n = rd(n, ST_SF_E6, E6_BITS, 1'b1);
        else
        begin
          fin   = 1'b1;
          extra = q.acc;
        end
      ST_SF_E6:
        if (q.acc == E6_ESC)
          n = rd(n, ST_SF_E7, E7_BITS, 1'b1);
        else
        begin
          fin   = 1'b1;
          extra = E4_ESC + q.acc;
        end
      ST_SF_E7:
      begin
        fin   = 1'b1;
        extra = E4_ESC + E6_ESC + q.acc;
      end
      ST_SF_END:
      begin
        n.prev_sf = q.res.sf[q.sub];
        n.sf_t = 1'b1;
        n = svc(n, ST_SUB_END, SV_AD_FLUSH, 4'h0, 8'h00);
      end
      // Half split parses the second sub-frame into slot one
      ST_SUB_END:
        if (split == HALF_FRAME_SPLIT && !q.sub)
        begin
          n.sub = 1'b1;
          n.st = ST_WL_CHK;
        end
        else
        begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
    endcase
    // Escape results land beyond the separation bounds
    if (fin && q.st != ST_SF_SYM)
      xval = q.hi_side ? UPPER_SEP + 12'sh001 + VAL_W'(extra)
                       : LOWER_SEP - 12'sh001 - VAL_W'(extra);
    if (fin)
    begin
      n.res.sf[q.sub][q.k] = SF_W'(pred + xval - VAL_W'(q.off));
      adv = 1'b1;
    end
    if (adv)
    begin
      if (q.k + 4'h1 < bands)
      begin
        n.k  = q.k + 4'h1;
        n.st = ST_SF_REQ;
      end
      else
        n.st = ST_SF_END;
    end
    // Request lines follow the wait state being entered
    n.br_req = n.st == ST_RD;
    n.sv.req = n.st == ST_SV || n.st == ST_AD_RD;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q      <= '0;
      q.cfg  <= CFG_RST;
      q.geom <= GEOM_RST;
    end
    else
      q <= n;
  end

  assign reg_rdata = q.rdata;
  assign br_req    = q.br_req;
  assign sv_req    = q.sv;
  assign result    = q.res;
  assign busy      = q.busy;

endmodule

// *** inc/tsp_pkg.sv ***
// Package: constants, encodings and carriers of the frame side-information parser
package tsp_pkg;

  // ==========================================================================
  // Sizes and value widths
  localparam int MAX_TILES = 4;
  localparam int MAX_BANDS = 12;
  localparam int MAX_ORDER = 8;
  localparam int COEF_W    = 4;
  localparam int SF_W      = 10;
  localparam int VAL_W     = 12;

  // ==========================================================================
  // Register offsets (byte addresses) and field positions
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CFG    = 4'h4;
  localparam logic [3:0] REG_GEOM   = 4'h8;
  localparam logic [3:0] REG_STAT   = 4'hC;
  localparam int CTRL_GO       = 0;
  localparam int CFG_INDEP     = 0;
  localparam int CFG_TWO_OK    = 1;
  localparam int CFG_PREV_PRED = 2;
  localparam int CFG_ENV       = 3;
  localparam int CFG_LTP       = 4;
  localparam int CFG_LTP_LOW   = 5;
  localparam int CFG_BW        = 6;
  localparam int CFG_SPLIT     = 8;
  localparam int CFG_CT        = 10;
  localparam int GEOM_RATE     = 0;
  localparam int GEOM_TILES    = 12;
  localparam int GEOM_BANDS    = 16;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] GEOM_RST = 32'h000C_40F4;

  // ==========================================================================
  // Harmonic-model rates in 0.1 kbps, coder types
  localparam logic [9:0] RATE_0 = 10'h060;
  localparam logic [9:0] RATE_1 = 10'h084;
  localparam logic [9:0] RATE_2 = 10'h0A4;
  localparam logic [9:0] RATE_3 = 10'h0F4;
  localparam logic [9:0] RATE_4 = 10'h140;
  localparam logic [9:0] RATE_5 = 10'h1E0;
  localparam logic [1:0] CT_VOICED  = 2'h1;
  localparam logic [1:0] CT_GENERIC = 2'h2;

  // ==========================================================================
  // Field widths, escape values, separation bounds
  localparam logic [3:0] ONE_BIT      = 4'h1;
  localparam logic [3:0] HM_IDX_BITS  = 4'h8;
  localparam logic [3:0] HM_MUL_BITS  = 4'h2;
  localparam logic [3:0] HM_GAIN_BITS = 4'h2;
  localparam logic [3:0] LSB_BITS     = 4'h2;
  localparam logic [3:0] E4_BITS      = 4'h4;
  localparam logic [3:0] E6_BITS      = 4'h6;
  localparam logic [3:0] E7_BITS      = 4'h7;
  localparam logic [7:0] E4_ESC       = 8'h0F;
  localparam logic [7:0] E6_ESC       = 8'h3F;
  localparam logic [4:0] SYM_LAST     = 5'h1A;
  localparam logic signed [VAL_W-1:0] LOWER_SEP = -12'sh00C;
  localparam logic signed [VAL_W-1:0] UPPER_SEP = 12'sh00C;
  localparam logic signed [VAL_W-1:0] CTX_LIM   = 12'sh003;

  // ==========================================================================
  // Table classes for scale-factor symbols
  localparam logic [3:0] TAB_SE00 = 4'h0;
  localparam logic [3:0] TAB_SE01 = 4'h1;
  localparam logic [3:0] TAB_SE02 = 4'h2;
  localparam logic [3:0] TAB_SE10 = 4'h3;
  localparam logic [3:0] TAB_SE11 = 4'h4;

  typedef enum logic [1:0] {LONG_FRAME_SPLIT, HALF_FRAME_SPLIT, QUARTER_FRAME_SPLIT} tsp_split_t;
  typedef enum logic [2:0] {SV_AD_BIT, SV_AD_SYM, SV_AD_INIT, SV_AD_FLUSH,
                            SV_VLC_ORDER, SV_VLC_COEF} tsp_cmd_t;
  typedef enum logic [4:0] {ST_IDLE, ST_RD, ST_AD_RD, ST_SV, ST_TNS_ON, ST_TNS_CNT,
                            ST_TNS_ORD, ST_TNS_COEF, ST_TNS_END, ST_HM_CHK, ST_HM_FLAG,
                            ST_HM_INT, ST_HM_GAIN, ST_WL_CHK, ST_WL_REUSE, ST_WL_LVL,
                            ST_WL_LVL2, ST_WL_NEXT, ST_WL_MODE, ST_WL_SAVE, ST_FLAT,
                            ST_ZERO, ST_SF_REQ, ST_SF_SYM, ST_SF_LSB, ST_SF_E4,
                            ST_SF_E6, ST_SF_E7, ST_SF_END, ST_SUB_END} tsp_state_e_t;

  // Request to the shared symbol service and its answer
  typedef struct packed {
    logic       req;
    tsp_cmd_t   cmd;
    logic [3:0] tab_a;
    logic [7:0] tab_b;
  } tsp_svreq_t;
  typedef struct packed {
    logic              ack;
    logic [7:0]        value;
    logic signed [7:0] offset;
  } tsp_svans_t;

  // Decoded side information of one frame
  typedef struct packed {
    logic [1:0]                              tns_active;
    logic [1:0][3:0]                         tns_order;
    logic [1:0][MAX_ORDER-1:0][COEF_W-1:0]   tns_coef;
    logic                                    hm_on;
    logic [7:0]                              hm_interval;
    logic [1:0]                              hm_gain;
    logic [1:0][MAX_TILES-1:0][1:0]          wl;
    logic [1:0]                              flat;
    logic [1:0]                              zero;
    logic [1:0][MAX_BANDS-1:0][SF_W-1:0]     sf;
  } tsp_result_t;

  typedef struct packed {
    tsp_state_e_t                   st;
    tsp_state_e_t                   ret;
    logic [3:0]                     need;
    logic [7:0]                     acc;
    logic signed [7:0]              off;
    logic [3:0]                     k;
    logic [3:0]                     ord;
    logic                           sub;
    logic                           filt;
    logic                           nfilt;
    logic                           hi_side;
    logic                           sf_t;
    logic                           busy;
    logic                           done;
    logic                           br_req;
    tsp_svreq_t                     sv;
    logic [MAX_TILES-1:0][1:0]      prev_wl;
    logic [MAX_BANDS-1:0][SF_W-1:0] prev_sf;
    tsp_result_t                    res;
    logic [31:0]                    cfg;
    logic [31:0]                    geom;
    logic [31:0]                    rdata;
  } tsp_state_t;

endpackage
